// >>> ccdt_pkg.sv
package ccdt_pkg;
    // register indices (printed offsets all word-aligned after scaling: some are not
    // multiples of four, so the printed value is the index and the byte address is index * 4)
    localparam logic [7:0] IDX_ROOT_SEL   = 8'h04;
    localparam logic [7:0] IDX_PB_COARSE  = 8'h0B;
    localparam logic [7:0] IDX_PB_FINE    = 8'h0C;
    localparam logic [7:0] IDX_PB_OSR_HI  = 8'h0D;
    localparam logic [7:0] IDX_PB_OSR_LO  = 8'h0E;
    localparam logic [7:0] IDX_RC_COARSE  = 8'h12;
    localparam logic [7:0] IDX_RC_FINE    = 8'h13;
    localparam logic [7:0] IDX_RC_OSR     = 8'h14;
    localparam logic [7:0] IDX_GP_SEL     = 8'h19;
    localparam logic [7:0] IDX_GP_DIV     = 8'h1A;
    localparam logic [7:0] IDX_AIF_CTRL   = 8'h1B;
    localparam logic [7:0] IDX_BC_SEL     = 8'h1D;
    localparam logic [7:0] IDX_BC_DIV     = 8'h1E;
    localparam logic [7:0] IDX_RC_PWR_ST  = 8'h24;
    localparam logic [7:0] IDX_PB_PWR_ST  = 8'h25;
    localparam logic [7:0] IDX_CH_PWR     = 8'h30;
    localparam int         ADDR_W         = 10;
    // field positions
    localparam int         POS_DIV_EN     = 7;
    localparam int         POS_BC_MASTER  = 3;
    localparam int         POS_RC_PWR     = 6;
    localparam int         POS_PB_PWR_A   = 7;
    localparam int         POS_PB_PWR_B   = 3;
    localparam int         POS_CH_PB      = 0;
    localparam int         POS_CH_RC      = 1;
    // reset values
    localparam logic [7:0] RST_REG        = 8'h00;
    localparam logic [7:0] RST_DIV        = 8'h01;
    // shutdown sequence length in modulator enables
    localparam int         SHUT_TICKS     = 64;
    localparam logic [1:0] RESP_OKAY      = 2'b00;
    localparam logic [1:0] RESP_SLVERR    = 2'b10;
endpackage : ccdt_pkg

// >>> ccdt_top.sv
`timescale 1ns/100ps
// Summary of operation
// - root clock picked by two-bit select
// - playback mod clock root over coarse*fine
// - record mod clock root over coarse*fine
// - playback divider fields in registers 11-14
// - record divider fields in registers 18-20
// - channel power-down runs internal shutdown sequence
// - playback status bits 7,3 in register 37
// - record status bit 6 in register 36
// - disabled record dividers borrow playback clocks
// - bit clock master drives divided clock
// - bit clock divider input four-way select
// - general clock divided 1-128 out
// - general clock source three-bit select
module ccdt_top (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic              clk_en,
    input  wire logic              mclk_pin,
    input  wire logic              bclk_pin_in,
    input  wire logic              gp1_pin_in,
    input  wire logic              pll_clk,
    output logic                   bclk_pin_out,
    output logic                   bclk_pin_oe,
    output logic                   gp_clk_out,
    output logic                   pb_mod_tick,
    output logic                   pb_fs_tick,
    output logic                   rc_mod_tick,
    output logic                   rc_fs_tick,
    input  wire logic [9:0]        s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [9:0]        s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready
);
    ////////////////////////////////////////////////////////////////////////////////
    // register storage
    logic [7:0] root_sel_r, pb_coarse_r, pb_fine_r, pb_osr_hi_r, pb_osr_lo_r;
    logic [7:0] rc_coarse_r, rc_fine_r, rc_osr_r, gp_sel_r, gp_div_r;
    logic [7:0] aif_ctrl_r, bc_sel_r, bc_div_r, ch_pwr_r;
    logic       pb_on_r, rc_on_r;

    localparam logic [7:0] IDX_ROOT_SEL  = ccdt_pkg::IDX_ROOT_SEL;
    localparam logic [7:0] IDX_PB_COARSE = ccdt_pkg::IDX_PB_COARSE;
    localparam logic [7:0] IDX_PB_FINE   = ccdt_pkg::IDX_PB_FINE;
    localparam logic [7:0] IDX_PB_OSR_HI = ccdt_pkg::IDX_PB_OSR_HI;
    localparam logic [7:0] IDX_PB_OSR_LO = ccdt_pkg::IDX_PB_OSR_LO;
    localparam logic [7:0] IDX_RC_COARSE = ccdt_pkg::IDX_RC_COARSE;
    localparam logic [7:0] IDX_RC_FINE   = ccdt_pkg::IDX_RC_FINE;
    localparam logic [7:0] IDX_RC_OSR    = ccdt_pkg::IDX_RC_OSR;
    localparam logic [7:0] IDX_GP_SEL    = ccdt_pkg::IDX_GP_SEL;
    localparam logic [7:0] IDX_GP_DIV    = ccdt_pkg::IDX_GP_DIV;
    localparam logic [7:0] IDX_AIF_CTRL  = ccdt_pkg::IDX_AIF_CTRL;
    localparam logic [7:0] IDX_BC_SEL    = ccdt_pkg::IDX_BC_SEL;
    localparam logic [7:0] IDX_BC_DIV    = ccdt_pkg::IDX_BC_DIV;
    localparam logic [7:0] IDX_CH_PWR    = ccdt_pkg::IDX_CH_PWR;
    localparam logic [7:0] IDX_RC_PWR_ST = ccdt_pkg::IDX_RC_PWR_ST;
    localparam logic [7:0] IDX_PB_PWR_ST = ccdt_pkg::IDX_PB_PWR_ST;
    localparam int         POS_DIV_EN    = ccdt_pkg::POS_DIV_EN;
    localparam int         POS_BC_MASTER = ccdt_pkg::POS_BC_MASTER;
    localparam int         POS_CH_PB     = ccdt_pkg::POS_CH_PB;
    localparam int         POS_CH_RC     = ccdt_pkg::POS_CH_RC;
    localparam int         SHUT_TICKS    = ccdt_pkg::SHUT_TICKS;

    function automatic logic [7:0] ccdt_idx(input logic [9:0] a);
        return a[9:2];
    endfunction : ccdt_idx

    // a divide field of zero means 128, so the range 1..128 fits seven bits
    function automatic logic [7:0] ccdt_div7(input logic [7:0] f);
        return (f[6:0] == 7'h00) ? 8'h80 : {1'b0, f[6:0]};
    endfunction : ccdt_div7

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers: sampled clocks become level signals for edge detection
    logic [3:0] src_s1_r, src_s2_r, src_s3_r;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            src_s1_r <= 4'h0;
            src_s2_r <= 4'h0;
            src_s3_r <= 4'h0;
        end else if (clk_en) begin
            src_s1_r <= {pll_clk, gp1_pin_in, bclk_pin_in, mclk_pin};
            src_s2_r <= src_s1_r;
            src_s3_r <= src_s2_r;
        end
    end
    logic [3:0] src_rise;
    assign src_rise = src_s2_r & ~src_s3_r;

    logic root_tick;
    assign root_tick = src_rise[root_sel_r[1:0]];

    ////////////////////////////////////////////////////////////////////////////////
    // divider chain; each stage counts enables of its parent
    logic [6:0] pbn_cnt_r, pbm_cnt_r, rcn_cnt_r, rcm_cnt_r;
    logic [9:0] pbo_cnt_r;
    logic [7:0] rco_cnt_r;
    logic       pb_proc_tick, rc_proc_tick, pb_fine_in, rc_fine_in, rc_osr_in;
    logic       rc_dividers_on;

    assign rc_dividers_on = rc_coarse_r[POS_DIV_EN] & rc_fine_r[POS_DIV_EN];

    assign pb_proc_tick = root_tick && pb_coarse_r[POS_DIV_EN] &&
                          ({1'b0, pbn_cnt_r} == ccdt_div7(pb_coarse_r) - 8'h01);
    assign pb_fine_in   = pb_proc_tick;
    assign pb_mod_tick  = pb_fine_in && pb_fine_r[POS_DIV_EN] &&
                          ({1'b0, pbm_cnt_r} == ccdt_div7(pb_fine_r) - 8'h01);
    assign pb_fs_tick   = pb_mod_tick &&
                          (pbo_cnt_r == {pb_osr_hi_r[1:0], pb_osr_lo_r} - 10'h001);

    // record side falls back on the playback clocks when its own dividers are off
    assign rc_proc_tick = rc_dividers_on ? (root_tick && ({1'b0, rcn_cnt_r} ==
                          ccdt_div7(rc_coarse_r) - 8'h01)) : pb_proc_tick;
    assign rc_fine_in   = rc_proc_tick;
    assign rc_osr_in    = rc_dividers_on ? (rc_fine_in && ({1'b0, rcm_cnt_r} ==
                          ccdt_div7(rc_fine_r) - 8'h01)) : pb_mod_tick;
    assign rc_mod_tick  = rc_osr_in;
    assign rc_fs_tick   = rc_osr_in && (rco_cnt_r == rc_osr_r - 8'h01);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pbn_cnt_r <= 7'h00;
            pbm_cnt_r <= 7'h00;
            pbo_cnt_r <= 10'h000;
        end else if (clk_en) begin
            if (!pb_coarse_r[POS_DIV_EN]) pbn_cnt_r <= 7'h00;
            else if (root_tick) pbn_cnt_r <= pb_proc_tick ? 7'h00 : pbn_cnt_r + 7'h01;
            if (!pb_fine_r[POS_DIV_EN]) pbm_cnt_r <= 7'h00;
            else if (pb_fine_in) pbm_cnt_r <= pb_mod_tick ? 7'h00 : pbm_cnt_r + 7'h01;
            if (pb_mod_tick) pbo_cnt_r <= pb_fs_tick ? 10'h000 : pbo_cnt_r + 10'h001;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rcn_cnt_r <= 7'h00;
            rcm_cnt_r <= 7'h00;
            rco_cnt_r <= 8'h00;
        end else if (clk_en) begin
            if (!rc_dividers_on) begin
                rcn_cnt_r <= 7'h00;
                rcm_cnt_r <= 7'h00;
            end else begin
                if (root_tick) rcn_cnt_r <= rc_proc_tick ? 7'h00 : rcn_cnt_r + 7'h01;
                if (rc_fine_in) rcm_cnt_r <= rc_osr_in ? 7'h00 : rcm_cnt_r + 7'h01;
            end
            if (rc_osr_in) rco_cnt_r <= rc_fs_tick ? 8'h00 : rco_cnt_r + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // bit clock and general-purpose clock outputs
    logic [3:0] bc_srcs;
    logic       bc_in;
    logic [6:0] bc_cnt_r;
    logic       bc_clk_r;
    assign bc_srcs = {rc_mod_tick, rc_proc_tick, pb_mod_tick, pb_proc_tick};
    assign bc_in   = bc_srcs[bc_sel_r[1:0]];

    // one-cycle pulse per divided enable: the rate is exact, the duty cycle is not even
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bc_cnt_r <= 7'h00;
            bc_clk_r <= 1'b0;
        end else if (clk_en) begin
            bc_clk_r <= 1'b0;
            if (bc_in && {1'b0, bc_cnt_r} == ccdt_div7(bc_div_r) - 8'h01) begin
                bc_cnt_r <= 7'h00;
                bc_clk_r <= 1'b1;
            end else if (bc_in) begin
                bc_cnt_r <= bc_cnt_r + 7'h01;
            end
        end
    end
    assign bclk_pin_oe  = aif_ctrl_r[POS_BC_MASTER];
    assign bclk_pin_out = bc_clk_r & aif_ctrl_r[POS_BC_MASTER];

    logic [7:0] gp_srcs;
    logic       gp_in;
    logic [6:0] gp_cnt_r;
    logic       gp_clk_r;
    assign gp_srcs = {rc_fs_tick, pb_fs_tick, rc_mod_tick, rc_proc_tick,
                      pb_mod_tick, pb_proc_tick, src_rise[3], root_tick};
    assign gp_in   = gp_srcs[gp_sel_r[2:0]];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gp_cnt_r <= 7'h00;
            gp_clk_r <= 1'b0;
        end else if (clk_en) begin
            gp_clk_r <= 1'b0;
            if (gp_in && {1'b0, gp_cnt_r} == ccdt_div7(gp_div_r) - 8'h01) begin
                gp_cnt_r <= 7'h00;
                gp_clk_r <= 1'b1;
            end else if (gp_in) begin
                gp_cnt_r <= gp_cnt_r + 7'h01;
            end
        end
    end
    assign gp_clk_out = gp_clk_r;

    ////////////////////////////////////////////////////////////////////////////////
    // channel power sequencing: each shutdown counts its own channel's modulator enables, so it
    // stalls if software stops the dividers early, which is why they must stay up
    logic [6:0] pb_shut_r, rc_shut_r;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pb_on_r   <= 1'b0;
            rc_on_r   <= 1'b0;
            pb_shut_r <= 7'h00;
            rc_shut_r <= 7'h00;
        end else if (clk_en) begin
            if (ch_pwr_r[POS_CH_PB]) begin
                pb_on_r   <= 1'b1;
                pb_shut_r <= 7'(SHUT_TICKS);
            end else if (pb_shut_r != 7'h00) begin
                if (pb_mod_tick) pb_shut_r <= pb_shut_r - 7'h01;
            end else begin
                pb_on_r <= 1'b0;
            end
            if (ch_pwr_r[POS_CH_RC]) begin
                rc_on_r   <= 1'b1;
                rc_shut_r <= 7'(SHUT_TICKS);
            end else if (rc_shut_r != 7'h00) begin
                if (rc_mod_tick) rc_shut_r <= rc_shut_r - 7'h01;
            end else begin
                rc_on_r <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave, one outstanding write and read
    logic       aw_got_r, w_got_r;
    logic [7:0] aw_idx_r, w_data_r;
    logic       w_lane_r;
    assign s_axi_awready = ~aw_got_r & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_got_r & ~s_axi_bvalid;

    function automatic logic ccdt_rw_hit(input logic [7:0] i);
        return i == IDX_ROOT_SEL || i == IDX_PB_COARSE || i == IDX_PB_FINE ||
               i == IDX_PB_OSR_HI || i == IDX_PB_OSR_LO || i == IDX_RC_COARSE ||
               i == IDX_RC_FINE || i == IDX_RC_OSR || i == IDX_GP_SEL ||
               i == IDX_GP_DIV || i == IDX_AIF_CTRL || i == IDX_BC_SEL ||
               i == IDX_BC_DIV || i == IDX_CH_PWR;
    endfunction : ccdt_rw_hit

    logic do_write;
    assign do_write = aw_got_r & w_got_r & ~s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_r     <= 1'b0;
            w_got_r      <= 1'b0;
            aw_idx_r     <= 8'h00;
            w_data_r     <= 8'h00;
            w_lane_r     <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= ccdt_pkg::RESP_OKAY;
        end else if (clk_en) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_r <= 1'b1;
                aw_idx_r <= ccdt_idx(s_axi_awaddr);
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_r  <= 1'b1;
                w_data_r <= s_axi_wdata[7:0];
                w_lane_r <= s_axi_wstrb[0];
            end
            if (do_write) begin
                aw_got_r     <= 1'b0;
                w_got_r      <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= ccdt_rw_hit(aw_idx_r) ? ccdt_pkg::RESP_OKAY
                                                      : ccdt_pkg::RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            root_sel_r  <= ccdt_pkg::RST_REG;
            pb_coarse_r <= ccdt_pkg::RST_DIV;
            pb_fine_r   <= ccdt_pkg::RST_DIV;
            pb_osr_hi_r <= ccdt_pkg::RST_REG;
            pb_osr_lo_r <= ccdt_pkg::RST_DIV;
            rc_coarse_r <= ccdt_pkg::RST_DIV;
            rc_fine_r   <= ccdt_pkg::RST_DIV;
            rc_osr_r    <= ccdt_pkg::RST_DIV;
            gp_sel_r    <= ccdt_pkg::RST_REG;
            gp_div_r    <= ccdt_pkg::RST_DIV;
            aif_ctrl_r  <= ccdt_pkg::RST_REG;
            bc_sel_r    <= ccdt_pkg::RST_REG;
            bc_div_r    <= ccdt_pkg::RST_DIV;
            ch_pwr_r    <= ccdt_pkg::RST_REG;
        end else if (clk_en && do_write && w_lane_r) begin
            unique case (aw_idx_r)
                IDX_ROOT_SEL:  root_sel_r  <= w_data_r;
                IDX_PB_COARSE: pb_coarse_r <= w_data_r;
                IDX_PB_FINE:   pb_fine_r   <= w_data_r;
                IDX_PB_OSR_HI: pb_osr_hi_r <= w_data_r;
                IDX_PB_OSR_LO: pb_osr_lo_r <= w_data_r;
                IDX_RC_COARSE: rc_coarse_r <= w_data_r;
                IDX_RC_FINE:   rc_fine_r   <= w_data_r;
                IDX_RC_OSR:    rc_osr_r    <= w_data_r;
                IDX_GP_SEL:    gp_sel_r    <= w_data_r;
                IDX_GP_DIV:    gp_div_r    <= w_data_r;
                IDX_AIF_CTRL:  aif_ctrl_r  <= w_data_r;
                IDX_BC_SEL:    bc_sel_r    <= w_data_r;
                IDX_BC_DIV:    bc_div_r    <= w_data_r;
                IDX_CH_PWR:    ch_pwr_r    <= w_data_r;
                default: ;
            endcase
        end
    end

    logic [7:0] rd_val;
    logic       rd_hit;
    logic [7:0] ar_idx;
    assign ar_idx = ccdt_idx(s_axi_araddr);
    always_comb begin
        rd_hit = 1'b1;
        rd_val = 8'h00;
        unique case (ar_idx)
            IDX_ROOT_SEL:  rd_val = root_sel_r;
            IDX_PB_COARSE: rd_val = pb_coarse_r;
            IDX_PB_FINE:   rd_val = pb_fine_r;
            IDX_PB_OSR_HI: rd_val = pb_osr_hi_r;
            IDX_PB_OSR_LO: rd_val = pb_osr_lo_r;
            IDX_RC_COARSE: rd_val = rc_coarse_r;
            IDX_RC_FINE:   rd_val = rc_fine_r;
            IDX_RC_OSR:    rd_val = rc_osr_r;
            IDX_GP_SEL:    rd_val = gp_sel_r;
            IDX_GP_DIV:    rd_val = gp_div_r;
            IDX_AIF_CTRL:  rd_val = aif_ctrl_r;
            IDX_BC_SEL:    rd_val = bc_sel_r;
            IDX_BC_DIV:    rd_val = bc_div_r;
            IDX_CH_PWR:    rd_val = ch_pwr_r;
            IDX_RC_PWR_ST: rd_val = {1'b0, rc_on_r, 6'h00};
            IDX_PB_PWR_ST: rd_val = {pb_on_r, 3'h0, pb_on_r, 3'h0};
            default:       rd_hit = 1'b0;
        endcase
    end

    assign s_axi_arready = ~s_axi_rvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= ccdt_pkg::RESP_OKAY;
        end else if (clk_en) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= {24'h00_0000, rd_val};
                s_axi_rresp  <= rd_hit ? ccdt_pkg::RESP_OKAY : ccdt_pkg::RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule : ccdt_top

// >>> ccdt_top_properties.sv
`timescale 1ns/100ps
module ccdt_top_properties (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        bclk_pin_out,
    input  wire logic        bclk_pin_oe,
    input  wire logic        pb_mod_tick,
    input  wire logic        pb_fs_tick,
    input  wire logic        rc_mod_tick,
    input  wire logic        rc_fs_tick,
    input  wire logic        s_axi_awvalid,
    input  wire logic        s_axi_awready,
    input  wire logic        s_axi_wvalid,
    input  wire logic        s_axi_wready,
    input  wire logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic        s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic        s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////////////////////////////////////////////////////////
    sequence wr_both; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
    sequence rd_take; s_axi_arvalid && s_axi_arready; endsequence
    a_write_answer: assert property (wr_both |-> ##[1:2] s_axi_bvalid)
        else $error("write response missing");
    a_read_answer: assert property (rd_take |=> s_axi_rvalid)
        else $error("read response missing");
    a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready &&
        s_axi_rdata[31:8] == 24'h000000)
        else $error("read channel misbehaves");
    a_bclk_gate: assert property (!bclk_pin_oe |-> !bclk_pin_out)
        else $error("bit clock driven without master");
    a_pb_rate: assert property (pb_fs_tick |-> pb_mod_tick ##1 !pb_mod_tick)
        else $error("playback rate tick off grid");
    a_rc_rate: assert property (rc_fs_tick |-> rc_mod_tick ##1 !rc_mod_tick)
        else $error("record rate tick off grid");
endmodule : ccdt_top_properties

bind ccdt_top ccdt_top_properties chk_u (.aclk, .aresetn, .bclk_pin_out, .bclk_pin_oe,
    .pb_mod_tick, .pb_fs_tick, .rc_mod_tick, .rc_fs_tick, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);

// >>> ccdt_clk_src.sv
`timescale 1ns/100ps
module ccdt_clk_src (
    input  wire logic bclk_pin_out,
    input  wire logic bclk_pin_oe,
    output logic      mclk_pin,
    output logic      bclk_pin_in,
    output logic      gp1_pin_in,
    output logic      pll_clk
);
    logic bclk_src = 1'b0;
    ////////////////////////////////////////////////////////////////////////////////////////////
    // source edges land on aclk falling edges, so interval counts are exact
    initial mclk_pin = 1'b0;
    initial gp1_pin_in = 1'b0;
    initial pll_clk = 1'b0;
    always #20 mclk_pin = ~mclk_pin;
    always #28 bclk_src = ~bclk_src;
    always #36 gp1_pin_in = ~gp1_pin_in;
    always #12 pll_clk = ~pll_clk;
    assign bclk_pin_in = bclk_pin_oe ? bclk_pin_out : bclk_src;
endmodule : ccdt_clk_src

// >>> codec_clock_divider_tree_test.sv
`timescale 1ns/100ps
module codec_clock_divider_tree_test;
    localparam logic [1:0] OK  = ccdt_pkg::RESP_OKAY;
    localparam logic [1:0] ERR = ccdt_pkg::RESP_SLVERR;
    localparam int RP[4] = '{10, 14, 18, 6};
    localparam int BP[4] = '{24, 72, 12, 24};
    localparam int GP[8] = '{6, 6, 12, 36, 6, 12, 144, 36};
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [9:0]  s_axi_awaddr = 10'h000;
    logic [9:0]  s_axi_araddr = 10'h000;
    logic [31:0] s_axi_wdata = 32'h00000000;
    logic        s_axi_awvalid = 1'b0;
    logic        s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic        mclk_pin, bclk_pin_in, gp1_pin_in, pll_clk, bclk_pin_out, bclk_pin_oe;
    logic        gp_clk_out, pb_mod_tick, pb_fs_tick, rc_mod_tick, rc_fs_tick;
    logic [5:0]  prv = 6'h00;
    int          failures = 0;
    int          tests_run = 0;
    int          cyc = 0;
    int          cnt;
    wire  [5:0]  tk = {gp_clk_out, bclk_pin_out, rc_fs_tick, rc_mod_tick, pb_fs_tick, pb_mod_tick};
    wire  [5:0]  rise = tk & ~prv;
    ccdt_top dut_u (.aclk, .aresetn, .clk_en(1'b1), .mclk_pin, .bclk_pin_in, .gp1_pin_in,
        .pll_clk, .bclk_pin_out, .bclk_pin_oe, .gp_clk_out, .pb_mod_tick, .pb_fs_tick,
        .rc_mod_tick, .rc_fs_tick, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    ccdt_clk_src src_u (.bclk_pin_out, .bclk_pin_oe, .mclk_pin, .bclk_pin_in, .gp1_pin_in,
        .pll_clk);
    ////////////////////////////////////////////////////////////////////////////////////////////
    always #2 aclk = ~aclk;
    always @(posedge aclk) prv <= tk;
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 40000) begin
            failures++;
            end_of_test();
        end
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        tests_run++;
        if (s !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    // ready is sampled at the falling edge: inputs only move at rising edges, so it is settled
    task automatic axw(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
        logic a, w, ra, rw;
        logic [1:0] rs;
        a = 1'b0;
        w = 1'b0;
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= {24'h000000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(a && w)) begin
            @(negedge aclk);
            ra = s_axi_awready && s_axi_awvalid;
            rw = s_axi_wready && s_axi_wvalid;
            @(posedge aclk);
            if (ra) s_axi_awvalid <= 1'b0;
            if (rw) s_axi_wvalid <= 1'b0;
            a = a | ra;
            w = w | rw;
        end
        ra = 1'b0;
        while (!ra) begin
            @(negedge aclk);
            ra = s_axi_bvalid;
            rs = s_axi_bresp;
            @(posedge aclk);
        end
        s_axi_bready <= 1'b0;
        chk("bresp", 32'(er), 32'(rs));
        @(posedge aclk);
    endtask : axw
    task automatic axr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
        logic ra;
        logic [31:0] rd;
        logic [1:0] rs;
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        ra = 1'b0;
        while (!ra) begin
            @(negedge aclk);
            ra = s_axi_arready;
            @(posedge aclk);
        end
        s_axi_arvalid <= 1'b0;
        ra = 1'b0;
        while (!ra) begin
            @(negedge aclk);
            ra = s_axi_rvalid;
            rd = s_axi_rdata;
            rs = s_axi_rresp;
            @(posedge aclk);
        end
        s_axi_rready <= 1'b0;
        chk("rdata", {24'h000000, d}, rd);
        chk("rresp", 32'(er), 32'(rs));
        @(posedge aclk);
    endtask : axr
    // two rises are skipped so a count left over from the old setting is not measured
    task automatic gap(input int k, input int e);
        int n;
        n = 0;
        repeat (2) do @(negedge aclk); while (!rise[k]);
        do begin
            @(negedge aclk);
            n++;
        end while (!rise[k]);
        @(posedge aclk);
        chk($sformatf("interval%0d", k), e, n);
    endtask : gap
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_of_test
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        axr(ccdt_pkg::IDX_PB_COARSE, ccdt_pkg::RST_DIV, OK);
        axr(ccdt_pkg::IDX_RC_FINE, ccdt_pkg::RST_DIV, OK);
        axr(ccdt_pkg::IDX_ROOT_SEL, ccdt_pkg::RST_REG, OK);
        axw(8'h05, 8'h5A, ERR);
        axr(8'h05, 8'h00, ERR);
        axw(ccdt_pkg::IDX_PB_COARSE, 8'h82, OK);
        axw(ccdt_pkg::IDX_PB_FINE, 8'h83, OK);
        axw(ccdt_pkg::IDX_PB_OSR_HI, 8'h00, OK);
        axw(ccdt_pkg::IDX_PB_OSR_LO, 8'h04, OK);
        axr(ccdt_pkg::IDX_PB_FINE, 8'h83, OK);
        for (int i = 0; i < 4; i++) begin
            axw(ccdt_pkg::IDX_ROOT_SEL, 8'(i), OK);
            gap(0, 6 * RP[i]);
        end
        gap(1, 144);
        gap(2, 36);
        axw(ccdt_pkg::IDX_RC_COARSE, 8'h81, OK);
        axw(ccdt_pkg::IDX_RC_FINE, 8'h82, OK);
        axw(ccdt_pkg::IDX_RC_OSR, 8'h03, OK);
        gap(2, 12);
        gap(3, 36);
        axw(ccdt_pkg::IDX_BC_DIV, 8'h82, OK);
        axw(ccdt_pkg::IDX_AIF_CTRL, 8'h08, OK);
        chk("bclk_oe", 32'h1, 32'(bclk_pin_oe));
        for (int i = 0; i < 4; i++) begin
            axw(ccdt_pkg::IDX_BC_SEL, 8'(i), OK);
            gap(4, BP[i]);
        end
        axw(ccdt_pkg::IDX_BC_DIV, 8'h80, OK);
        gap(4, 1536);
        axw(ccdt_pkg::IDX_AIF_CTRL, 8'h00, OK);
        chk("bclk_oe", 32'h0, 32'(bclk_pin_oe));
        axw(ccdt_pkg::IDX_GP_DIV, 8'h81, OK);
        for (int i = 0; i < 8; i++) begin
            axw(ccdt_pkg::IDX_GP_SEL, 8'(i), OK);
            gap(5, GP[i]);
        end
        axw(ccdt_pkg::IDX_CH_PWR, 8'h03, OK);
        repeat (20) @(posedge aclk);
        axr(ccdt_pkg::IDX_PB_PWR_ST, 8'h88, OK);
        axr(ccdt_pkg::IDX_RC_PWR_ST, 8'h40, OK);
        axw(ccdt_pkg::IDX_CH_PWR, 8'h00, OK);
        axr(ccdt_pkg::IDX_PB_PWR_ST, 8'h88, OK);
        repeat (2500) @(posedge aclk);
        axr(ccdt_pkg::IDX_PB_PWR_ST, 8'h00, OK);
        axr(ccdt_pkg::IDX_RC_PWR_ST, 8'h00, OK);
        axw(ccdt_pkg::IDX_PB_FINE, 8'h03, OK);
        axw(ccdt_pkg::IDX_PB_COARSE, 8'h02, OK);
        cnt = 0;
        repeat (300) @(negedge aclk) cnt = cnt + int'(rise[0]);
        @(posedge aclk);
        chk("pb_mod_off", 32'h0, cnt);
        end_of_test();
    end
endmodule : codec_clock_divider_tree_test
